// ===== pkg/hfcr_pkg.sv
package hfcr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;
  localparam logic [7:0]  CFG_INDEX  = 8'h1a;
  localparam logic [7:0]  STAT_INDEX = 8'h20;
  localparam logic [11:0] CFG_ADDR   = {2'h0, CFG_INDEX, 2'h0};
  localparam logic [11:0] STAT_ADDR  = {2'h0, STAT_INDEX, 2'h0};

  // ----------------------------------------------------------------
  // Field positions of the loop configuration register and the status word
  // ----------------------------------------------------------------
  localparam int TYPE_BIT   = 7;
  localparam int BRAKE_LSB  = 4;
  localparam int LOOP_LSB   = 2;
  localparam int BEMF_LSB   = 0;
  localparam int BUSY_BIT   = 8;

  // ----------------------------------------------------------------
  // Reset values and special codes
  // ----------------------------------------------------------------
  localparam logic       TYPE_RST  = 1'h0;
  localparam logic [2:0] BRAKE_RST = 3'h3;
  localparam logic [1:0] LOOP_RST  = 2'h1;
  localparam logic [1:0] BEMF_RST  = 2'h2;
  localparam logic [2:0] BRAKE_OFF = 3'h7;

  // Brake multipliers for codes 6 down to 0; code 7 disables braking.
  localparam logic [6:0][4:0] BRAKE_MULT_TAB =
    {5'h10, 5'h08, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01};

  // Back-EMF amplifier gains in units of 1/10000, codes 3 down to 0.
  localparam logic [3:0][17:0] BEMF_ERM_TAB =
    {18'h07530, 18'h03552, 18'h01ec3, 18'h009f6};
  localparam logic [3:0][17:0] BEMF_LRA_TAB =
    {18'h36ee8, 18'h249f0, 18'h124f8, 18'h0927c};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       lra;
    logic [2:0] brake_code;
    logic [1:0] loop_gain;
    logic [1:0] bemf_code;
  } hfcr_cfg_type;

  typedef struct packed {
    logic        lra;
    logic        brake_en;
    logic [4:0]  brake_mult;
    logic [1:0]  loop_gain;
    logic [17:0] backemf_amp_gain;
  } hfcr_drive_type;

  typedef enum logic {OP_IDLE, OP_BUSY} hfcr_op_type;

  localparam hfcr_cfg_type CFG_RST = '{
    lra:        TYPE_RST,
    brake_code: BRAKE_RST,
    loop_gain:  LOOP_RST,
    bemf_code:  BEMF_RST
  };

endpackage

// ===== verilog/hfcr_decode.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Turns the raw register fields into the gains used by the loop.
// ------------------------------------------------------------------
module hfcr_decode
  import hfcr_pkg::*;
(
  input  hfcr_cfg_type   cfg,
  output hfcr_drive_type drive
);

  // Brake multiplier; the disabled code returns zero.
  function automatic logic [4:0] brake_mult(input logic [2:0] code);
    logic [4:0] m;
    m = 5'h00;
    if (code != BRAKE_OFF)
    begin
      m = BRAKE_MULT_TAB[code];
    end
    return m;
  endfunction

  // The amplifier gain table depends on the actuator type.
  function automatic logic [17:0] backemf_amp_gain(input logic lra, input logic [1:0] code);
    logic [17:0] g;
    g = lra ? BEMF_LRA_TAB[code] : BEMF_ERM_TAB[code];
    return g;
  endfunction

  // Pure combinational decode of every field.
  always_comb
  begin
    drive.lra        = cfg.lra;
    drive.brake_en   = (cfg.brake_code != BRAKE_OFF);
    drive.brake_mult = brake_mult(cfg.brake_code);
    drive.loop_gain  = cfg.loop_gain;
    drive.backemf_amp_gain  = backemf_amp_gain(cfg.lra, cfg.bemf_code);
  end

endmodule

// ===== verilog/hfcr_top.sv
`timescale 1ns/100ps

// Notes on behaviour
// - Bit 7 selects actuator: 0 rotating mass, 1 linear resonant; resets to 0.
// - Bits 6-4 give brake ratio 1x,2x,3x,4x,6x,8x,16x; code 7 disables braking.
// - Bits 3-2 set loop settling speed; code 0 is the slowest.
// - Reset values: brake ratio code 3, loop gain code 1.
// - Bits 1-0 set amplifier gain per actuator type; reset 2; calibration overwrites.

module hfcr_top
  import hfcr_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              ARST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [DATA_W-1:0] PWDATA,
  output logic      [DATA_W-1:0] PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              OP_START,
  input  wire logic              OP_DONE,
  input  wire logic              CAL_DONE,
  input  wire logic [1:0]        CAL_GAIN,
  output hfcr_drive_type         LOOP_CFG,
  output logic                   OP_ACTIVE
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  hfcr_cfg_type      cfg_q;
  hfcr_cfg_type      cfg_d;
  hfcr_cfg_type      act_cfg_q;
  hfcr_drive_type    drive_now;
  hfcr_drive_type    drive_q;
  hfcr_op_type       op_q;
  hfcr_op_type       op_d;
  logic [DATA_W-1:0] rdata_q;
  logic              err_q;
  logic              setup;
  logic              access;
  logic              hit_cfg;
  logic              hit_stat;
  logic              wr_cfg;
  logic              init_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  // The slave never inserts wait states, so every access phase ends
  // at its first edge. Read data and the error flag are prepared in
  // the setup cycle; read data comes straight from a flip-flop, the error flag is gated with the access phase.
  assign setup    = PSEL & ~PENABLE;
  assign access   = PSEL & PENABLE;
  assign hit_cfg  = (PADDR == CFG_ADDR);
  assign hit_stat = (PADDR == STAT_ADDR);
  assign wr_cfg   = access & PWRITE & hit_cfg;
  assign PREADY   = 1'b1;
  assign PRDATA   = rdata_q;
  assign PSLVERR  = err_q & access;

  // Read data for the coming access phase; upper bits read as zero except the status busy flag in bit 8.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rdata_q <= '0;
    end
    else if (setup)
    begin
      rdata_q <= '0;
      if (!PWRITE && hit_cfg)
      begin
        rdata_q[7:0] <= cfg_q;
      end
      else if (!PWRITE && hit_stat)
      begin
        rdata_q[7:0]    <= act_cfg_q;
        rdata_q[BUSY_BIT] <= (op_q == OP_BUSY);
      end
    end
  end

  // Unmapped addresses and writes to the status word are refused.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      err_q <= 1'b0;
    end
    else if (setup)
    begin
      err_q <= ~(hit_cfg | (hit_stat & ~PWRITE));
    end
  end

  // ----------------------------------------------------------------
  // Loop configuration register
  // ----------------------------------------------------------------

  // Next value: the host write lands first, then a calibration result
  // overrides the gain field, so the hardware update wins a collision.
  always_comb
  begin
    cfg_d = cfg_q;
    if (wr_cfg)
    begin
      cfg_d = hfcr_cfg_type'(PWDATA[7:0]);
    end
    if (CAL_DONE)
    begin
      cfg_d.bemf_code = CAL_GAIN;
    end
  end

  // Reset defaults cover the actuator type, ratio, loop and gain.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cfg_q <= CFG_RST;
    end
    else
    begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // Operation tracking
  // ----------------------------------------------------------------

  // A drive or calibration run spans from its start to its done pulse.
  // A start while busy restarts the run with a fresh snapshot.
  always_comb
  begin
    op_d = op_q;
    case (op_q)
      OP_IDLE:
      begin
        if (OP_START)
        begin
          op_d = OP_BUSY;
        end
      end
      OP_BUSY:
      begin
        if (OP_DONE && !OP_START)
        begin
          op_d = OP_IDLE;
        end
      end
      default:
      begin
        op_d = OP_IDLE;
      end
    endcase
  end

  // State register of the run tracker.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      op_q <= OP_IDLE;
    end
    else
    begin
      op_q <= op_d;
    end
  end

  // The run flag is a plain decode of the one-bit state register.
  assign OP_ACTIVE = (op_q == OP_BUSY);

  // ----------------------------------------------------------------
  // Snapshot used by the running operation
  // ----------------------------------------------------------------

  // Gains follow the live register; only the snapshot below is used.
  hfcr_decode hfcr_decode_inst (
    .cfg   (cfg_q),
    .drive (drive_now)
  );

  // Settings are frozen at the start of each operation. The trade-off
  // is that a mid-run write waits for the next run, which keeps the
  // loop from seeing a gain change halfway through a waveform.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      act_cfg_q <= CFG_RST;
    end
    else if (OP_START)
    begin
      act_cfg_q <= cfg_q;
    end
  end

  // Decoded gains for the analog loop, registered at the same moment.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      drive_q <= '0;
    end
    else if (OP_START)
    begin
      drive_q <= drive_now;
    end
  end

  // The loop sees only the frozen copy, never the live register.
  assign LOOP_CFG = drive_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // Marks the first cycle after reset release for the default check.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      init_q <= 1'b0;
    end
    else
    begin
      init_q <= 1'b1;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_cfg_setup;
    PSEL && !PENABLE && PWRITE && (PADDR == CFG_ADDR);
  endsequence

  sequence s_cfg_access;
    PSEL && PENABLE && PWRITE && (PADDR == CFG_ADDR) && !CAL_DONE;
  endsequence

  sequence s_cfg_rd;
    PSEL && !PENABLE && !PWRITE && (PADDR == CFG_ADDR) && !wr_cfg && !CAL_DONE;
  endsequence

  a_type_select: assert property (
    OP_START |=> (LOOP_CFG.lra == $past(cfg_q[TYPE_BIT]))
  ) else $error("Actuator type not taken from bit 7.");

  a_brake_off: assert property (
    OP_START |=> (LOOP_CFG.brake_en == ($past(cfg_q.brake_code) != BRAKE_OFF))
  ) else $error("Brake enable does not follow code 7.");

  a_brake_max: assert property (
    OP_START && (cfg_q.brake_code == 3'h6) |=> (LOOP_CFG.brake_mult == 5'h10)
  ) else $error("Brake code 6 does not give 16x.");

  a_loop_gain: assert property (
    OP_START |=> (LOOP_CFG.loop_gain == $past(cfg_q[LOOP_LSB +: 2]))
  ) else $error("Loop gain not taken from bits 3-2.");

  a_reset_dflt: assert property (
    !init_q |-> (cfg_q.brake_code == 3'h3) && (cfg_q.loop_gain == 2'h1)
  ) else $error("Wrong defaults after reset.");

  a_cal_over: assert property (
    CAL_DONE |=> (cfg_q.bemf_code == $past(CAL_GAIN))
  ) else $error("Calibration gain not stored.");

  a_gain_decode: assert property (
    OP_START && (cfg_q.bemf_code == 2'h2) |=>
      (LOOP_CFG.backemf_amp_gain == (LOOP_CFG.lra ? 18'h249f0 : 18'h03552))
  ) else $error("Amplifier gain decode wrong for code 2.");

  a_write_lands: assert property (
    s_cfg_setup ##1 s_cfg_access |=> (cfg_q == $past(PWDATA[7:0]))
  ) else $error("Configuration write not stored.");

  a_read_back: assert property (
    s_cfg_rd ##1 (PSEL && PENABLE) |-> (PRDATA == {24'h000000, cfg_q}) && !PSLVERR
  ) else $error("Configuration read returns wrong data.");

  a_next_op: assert property (
    OP_START && !wr_cfg && !CAL_DONE |=> (act_cfg_q == cfg_q)
  ) else $error("Operation snapshot differs from register.");

  // The calibration result keeps its gain code even when a host write lands.
  a_cal_collide: assert property (
    wr_cfg && CAL_DONE |=>
      (cfg_q[7:2] == $past(PWDATA[7:2])) && (cfg_q.bemf_code == $past(CAL_GAIN))
  ) else $error("Calibration and host write collided wrongly.");

  a_status_ro: assert property (
    PSEL && PENABLE && PWRITE && (PADDR == STAT_ADDR) && !CAL_DONE |=> $stable(cfg_q)
  ) else $error("Write to the status word changed the configuration.");

  a_busy_set: assert property (
    OP_START |=> OP_ACTIVE
  ) else $error("Run flag not raised by a start.");

endmodule

// ===== verif/test_haptic_feedback_control_reg.sv
`timescale 1ns/100ps

module test_haptic_feedback_control_reg
  import hfcr_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic              CORE_CLK = 1'b0;
  logic              ARST_N   = 1'b0;
  logic              PSEL     = 1'b0;
  logic              PENABLE  = 1'b0;
  logic              PWRITE   = 1'b0;
  logic [ADDR_W-1:0] PADDR    = '0;
  logic [DATA_W-1:0] PWDATA   = '0;
  logic [DATA_W-1:0] PRDATA;
  logic              PREADY;
  logic              PSLVERR;
  logic              OP_START = 1'b0;
  logic              OP_DONE  = 1'b0;
  logic              CAL_DONE = 1'b0;
  logic [1:0]        CAL_GAIN = 2'h0;
  hfcr_drive_type    LOOP_CFG;
  logic              OP_ACTIVE;
  int                n_mismatch = 0;
  int                cmp_count  = 0;
  int                cyc        = 0;
  logic [DATA_W-1:0] rd;
  logic              er;
  logic [7:0]        c;

  // Expected gains, written out independently of the design's tables.
  logic [4:0]  bm [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
  logic [17:0] ge [4] = '{18'h009f6, 18'h01ec3, 18'h03552, 18'h07530};
  logic [17:0] gl [4] = '{18'h0927c, 18'h124f8, 18'h249f0, 18'h36ee8};

  // ----------------------------------------------------------------
  // Clock, design and watchdog
  // ----------------------------------------------------------------
  always #25 CORE_CLK = ~CORE_CLK;

  hfcr_top hfcr_top_inst (
    .CORE_CLK  (CORE_CLK),
    .ARST_N    (ARST_N),
    .PSEL      (PSEL),
    .PENABLE   (PENABLE),
    .PWRITE    (PWRITE),
    .PADDR     (PADDR),
    .PWDATA    (PWDATA),
    .PRDATA    (PRDATA),
    .PREADY    (PREADY),
    .PSLVERR   (PSLVERR),
    .OP_START  (OP_START),
    .OP_DONE   (OP_DONE),
    .CAL_DONE  (CAL_DONE),
    .CAL_GAIN  (CAL_GAIN),
    .LOOP_CFG  (LOOP_CFG),
    .OP_ACTIVE (OP_ACTIVE)
  );

  // The whole run needs well under a thousand cycles; a hang ends here.
  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One APB transfer; each starts one edge after the last to avoid double drives.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge CORE_CLK);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do @(posedge CORE_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_drive(input hfcr_drive_type got, input hfcr_drive_type exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pulses one input for a single cycle and lets the answer land.
  task automatic pulse(input int which);
    @(posedge CORE_CLK);
    if (which == 0) OP_START <= 1'b1;
    else if (which == 1) OP_DONE <= 1'b1;
    else CAL_DONE <= 1'b1;
    @(posedge CORE_CLK);
    OP_START <= 1'b0;
    OP_DONE  <= 1'b0;
    CAL_DONE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  function automatic hfcr_drive_type exp_drive(input logic [7:0] v);
    exp_drive.lra        = v[7];
    exp_drive.brake_en   = (v[6:4] != 3'h7);
    exp_drive.brake_mult = bm[v[6:4]];
    exp_drive.loop_gain  = v[3:2];
    exp_drive.backemf_amp_gain  = v[7] ? gl[v[1:0]] : ge[v[1:0]];
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    chk_drive(LOOP_CFG, '0);
    chk({31'h0, OP_ACTIVE}, 32'h0);
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(rd, 32'h36);
    chk({31'h0, er}, 32'h0);
    // Every brake code, loop code, gain code and both actuator types.
    for (int i = 0; i < 8; i++)
    begin
      c = {i[0], i[2:0], i[1:0], i[2:1]};
      apb(1'b1, CFG_ADDR, {24'h0, c});
      apb(1'b0, CFG_ADDR, 32'h0);
      chk(rd, {24'h0, c});
      pulse(0);
      chk_drive(LOOP_CFG, exp_drive(c));
      chk({31'h0, OP_ACTIVE}, 32'h1);
      apb(1'b0, STAT_ADDR, 32'h0);
      chk(rd, {23'h0, 1'b1, c});
      pulse(1);
      chk({31'h0, OP_ACTIVE}, 32'h0);
    end
    // A write during a run must wait for the next start.
    pulse(0);
    apb(1'b1, CFG_ADDR, 32'hf0);
    chk_drive(LOOP_CFG, exp_drive(c));
    pulse(0);
    chk_drive(LOOP_CFG, exp_drive(8'hf0));
    pulse(1);
    // Calibration replaces only the amplifier gain code; the other
    // fields are programmed first, as software is expected to do.
    apb(1'b1, CFG_ADDR, 32'hf0);
    CAL_GAIN <= 2'h3;
    pulse(2);
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(rd, 32'hf3);
    // A host write and a calibration result at one edge: the gain code
    // comes from calibration, the other fields from the host.
    fork
      apb(1'b1, CFG_ADDR, 32'h5c);
      begin
        @(posedge CORE_CLK);
        pulse(2);
      end
    join
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(rd, 32'h5f);
    // Refused places: unmapped read and write to the read-only status.
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, STAT_ADDR, 32'h1ff);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk(rd, 32'hf0);
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(rd, 32'h5f);
    // A second reset brings back the defaults.
    @(posedge CORE_CLK);
    ARST_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(rd, 32'h36);
    wrap_up();
  end
endmodule
